// ---- core/fnd_pkg.sv ----
// Contract
// - Control bits 00 select feedback divider word
// - Nine-bit whole part sets integer division
// - Controller keeps partial numerator within denominator
// - Boost bit forces maximum charge pump current
// - Boost switch selection grounds test pin only while the boost bit is set, else the pin is released and pulled high
// - Control bits 01 select reference divider word
// - Load control bit steers field to resync
// - Three bits choose test output source
// - Short window: 24 good cycles set lock
// - Lock holds until new channel or large error
// - Controller requires 8/9 above 2 GHz
// - Division value respects prescaler minimum
// - Reference divider ratio from 1 to 15
// - Counters set overall feedback division ratio
// - Output equals comparator rate times whole-plus-fraction
// - Denominator applies after later feedback word
// - Long window: 40 good cycles set lock
package fnd_pkg;
    // ==========================================================
    // Serial word layout
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_FEEDBACK = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam int CTL_LSB = 0;
    localparam int BOOST_BIT = 23;
    localparam int WHOLE_LSB = 14;
    localparam int WHOLE_W = 9;
    localparam int PART_LSB = 2;
    localparam int PART_W = 12;
    localparam int LOAD_CTL_BIT = 23;
    localparam int TEST_SEL_LSB = 20;
    localparam int PRESC_BIT = 18;
    localparam int RDIV_LSB = 14;
    localparam int RDIV_W = 4;
    localparam int DEN_LSB = 2;
    // ==========================================================
    // Test output selections
    typedef enum logic [2:0] {
        FND_TO_TRI = 3'b000,
        FND_TO_DLOCK = 3'b001,
        FND_TO_FBDIV = 3'b010,
        FND_TO_HIGH = 3'b011,
        FND_TO_REFDIV = 3'b100,
        FND_TO_ALOCK = 3'b101,
        FND_TO_BOOST = 3'b110,
        FND_TO_LOW = 3'b111
    } fnd_test_sel_e;
    // ==========================================================
    // Lock detect and prescaler limits
    localparam logic [5:0] LOCK_CNT_SHORT = 6'h18;
    localparam logic [5:0] LOCK_CNT_LONG = 6'h28;
    localparam logic [9:0] NMIN_PRESC4 = 10'h01F;
    localparam logic [9:0] NMIN_PRESC8 = 10'h05B;
    localparam logic [3:0] CP_MAX = 4'hF;
    // ==========================================================
    // Host timing and register map
    localparam int SCLK_HALF_NS = 20;
    localparam int CLK_NS = 10;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] OFS_WORD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam int EV_SENT = 0;
    localparam int EV_REFUSED = 1;
    localparam int EV_PIN_RISE = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
endpackage : fnd_pkg

// ---- core/fnd_if.sv ----
`timescale 1ns/100ps
// ==========================================================
// Three-wire programming link plus the test output pin
interface fnd_if;
    logic sclk; // Serial clock, data taken on its rise
    logic sdata; // Serial data, most significant bit first
    logic latch_en; // Latch strobe, word transfers on its rise
    logic test_out; // Test pin level driven by the device
    logic test_oe; // High while the device drives the pin
    logic test_pin; // Resolved pin, pulled up when undriven
    assign test_pin = test_oe ? test_out : 1'b1;
    modport dev (input sclk, input sdata, input latch_en, output test_out, output test_oe);
    modport host (output sclk, output sdata, output latch_en, input test_pin);
endinterface : fnd_if

// ---- core/fnd_dev.sv ----
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// ==========================================================
// Synthesizer program registers, dividers and lock detect
module fnd_dev (
    input wire logic ref_clk,
    input wire logic nrst,
    fnd_if.dev link,
    input wire logic [3:0] cp_setting,
    input wire logic lock_window_length_bit,
    input wire logic reference_input,
    input wire logic high_freq_input,
    input wire logic pd_cycle,
    input wire logic pd_err_lt15,
    input wire logic pd_err_gt30,
    output logic [3:0] cp_current,
    output logic prescaler_select_bit,
    output logic [8:0] whole_part_value,
    output logic [11:0] denominator_value,
    output logic [11:0] resync_delay,
    output logic ref_div_out,
    output logic fb_div_out,
    output logic digital_lock
);
    // ==========================================================
    // Declarations
    logic sclk_q; // Previous serial clock level
    logic le_q; // Previous latch strobe level
    logic [fnd_pkg::WORD_W-1:0] shift_q; // Assembled serial word
    logic [fnd_pkg::PART_W-1:0] partial_step_numerator; // Fraction numerator
    logic [fnd_pkg::PART_W-1:0] den_pend_q; // Denominator waiting to apply
    logic boost_charge_current; // Boost flag
    logic [2:0] test_sel_q; // Test output selection
    logic [fnd_pkg::RDIV_W-1:0] rdiv_q; // Reference divide ratio
    logic wr_fb; // Feedback word transfer this cycle
    logic wr_ref; // Reference word transfer this cycle
    logic [1:0] ctl; // Control bits of the assembled word
    logic ref_q; // Previous reference level
    logic [3:0] rcnt_q; // Reference edge counter
    logic hf_q; // Previous high frequency level
    logic [9:0] ncnt_q; // Feedback edge counter
    logic [9:0] nlim_q; // Edges in the current feedback cycle
    logic [fnd_pkg::PART_W:0] acc_q; // Fraction accumulator
    logic [fnd_pkg::PART_W:0] acc_sum; // Accumulator plus numerator
    logic carry; // Accumulator overflow
    logic [5:0] lcnt_q; // Good comparator cycles in a row
    logic [5:0] ltarget; // Cycles needed for lock
    logic alock_q; // Last comparator cycle was good
    logic [2:0] sel;

    // ==========================================================
    // Serial shift and word transfer
    assign ctl = shift_q[fnd_pkg::CTL_LSB +: 2];
    assign wr_fb = link.latch_en && !le_q && ctl == fnd_pkg::SEL_FEEDBACK;
    assign wr_ref = link.latch_en && !le_q && ctl == fnd_pkg::SEL_REFERENCE;

    // Edge history of link pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
            le_q <= 1'b0;
        end else begin
            sclk_q <= link.sclk;
            le_q <= link.latch_en;
        end
    end

    // Shift a bit in on each serial clock rise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_q <= 24'h000000;
        end else if (link.sclk && !sclk_q) begin
            shift_q <= {shift_q[fnd_pkg::WORD_W-2:0], link.sdata};
        end
    end

    // Feedback divider word fields
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            whole_part_value <= 9'h000;
            partial_step_numerator <= 12'h000;
            boost_charge_current <= 1'b0;
        end else if (wr_fb) begin
            whole_part_value <= shift_q[fnd_pkg::WHOLE_LSB +: fnd_pkg::WHOLE_W];
            partial_step_numerator <= shift_q[fnd_pkg::PART_LSB +: fnd_pkg::PART_W];
            boost_charge_current <= shift_q[fnd_pkg::BOOST_BIT];
        end
    end

    // Reference word fields; load control picks resync or denominator
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            den_pend_q <= 12'h000;
            resync_delay <= 12'h000;
            test_sel_q <= 3'h0;
            prescaler_select_bit <= 1'b0;
            rdiv_q <= 4'h0;
        end else if (wr_ref) begin
            if (shift_q[fnd_pkg::LOAD_CTL_BIT]) begin
                resync_delay <= shift_q[fnd_pkg::DEN_LSB +: fnd_pkg::PART_W];
            end else begin
                den_pend_q <= shift_q[fnd_pkg::DEN_LSB +: fnd_pkg::PART_W];
            end
            test_sel_q <= shift_q[fnd_pkg::TEST_SEL_LSB +: 3];
            prescaler_select_bit <= shift_q[fnd_pkg::PRESC_BIT];
            rdiv_q <= shift_q[fnd_pkg::RDIV_LSB +: fnd_pkg::RDIV_W];
        end
    end

    // Denominator is double buffered behind a feedback word write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            denominator_value <= 12'h000;
        end else if (wr_fb) begin
            denominator_value <= den_pend_q;
        end
    end

    // Charge pump current, forced to maximum while boosted
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cp_current <= 4'h0;
        end else begin
            cp_current <= boost_charge_current ? fnd_pkg::CP_MAX : cp_setting;
        end
    end

    // ==========================================================
    // Reference divider: one pulse per R reference rises
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ref_q <= 1'b0;
            rcnt_q <= 4'h0;
            ref_div_out <= 1'b0;
        end else begin
            ref_q <= reference_input;
            ref_div_out <= 1'b0;
            if (reference_input && !ref_q) begin
                // Ratio 0 is outside the range and acts as 1
                if (rcnt_q + 4'h1 >= rdiv_q) begin
                    rcnt_q <= 4'h0;
                    ref_div_out <= 1'b1;
                end else begin
                    rcnt_q <= rcnt_q + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // Fractional feedback divider: N or N+1 per cycle
    assign acc_sum = acc_q + {1'b0, partial_step_numerator};
    assign carry = denominator_value != 12'h000 && acc_sum >= {1'b0, denominator_value};

    // Count input rises, end a cycle at the current limit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hf_q <= 1'b0;
            ncnt_q <= 10'h000;
            nlim_q <= 10'h000;
            acc_q <= 13'h0000;
            fb_div_out <= 1'b0;
        end else begin
            hf_q <= high_freq_input;
            fb_div_out <= 1'b0;
            if (high_freq_input && !hf_q) begin
                if (ncnt_q + 10'h001 >= nlim_q) begin
                    ncnt_q <= 10'h000;
                    fb_div_out <= 1'b1;
                    acc_q <= carry ? acc_sum - {1'b0, denominator_value} : acc_sum;
                    nlim_q <= {1'b0, whole_part_value} + {9'h000, carry};
                end else begin
                    ncnt_q <= ncnt_q + 10'h001;
                end
            end
        end
    end

    // ==========================================================
    // Digital lock detect
    assign ltarget = lock_window_length_bit ? fnd_pkg::LOCK_CNT_LONG : fnd_pkg::LOCK_CNT_SHORT;

    // Count good comparator cycles; large error or new channel drops lock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lcnt_q <= 6'h00;
            digital_lock <= 1'b0;
            alock_q <= 1'b0;
        end else if (wr_fb) begin
            lcnt_q <= 6'h00;
            digital_lock <= 1'b0;
        end else if (pd_cycle) begin
            alock_q <= pd_err_lt15;
            if (pd_err_gt30) begin
                lcnt_q <= 6'h00;
                digital_lock <= 1'b0;
            end else if (pd_err_lt15) begin
                if (lcnt_q + 6'h01 >= ltarget) begin
                    digital_lock <= 1'b1;
                end else begin
                    lcnt_q <= lcnt_q + 6'h01;
                end
            end else begin
                lcnt_q <= 6'h00;
            end
        end
    end

    // ==========================================================
    // Test output multiplexer, registered
    assign sel = test_sel_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            link.test_out <= 1'b0;
            link.test_oe <= 1'b0;
        end else begin
            case (sel)
                fnd_pkg::FND_TO_TRI: begin
                    link.test_out <= 1'b0;
                    link.test_oe <= 1'b0;
                end
                fnd_pkg::FND_TO_DLOCK: begin
                    link.test_out <= digital_lock;
                    link.test_oe <= 1'b1;
                end
                fnd_pkg::FND_TO_FBDIV: begin
                    link.test_out <= fb_div_out;
                    link.test_oe <= 1'b1;
                end
                fnd_pkg::FND_TO_HIGH: begin
                    link.test_out <= 1'b1;
                    link.test_oe <= 1'b1;
                end
                fnd_pkg::FND_TO_REFDIV: begin
                    link.test_out <= ref_div_out;
                    link.test_oe <= 1'b1;
                end
                fnd_pkg::FND_TO_ALOCK: begin
                    link.test_out <= alock_q;
                    link.test_oe <= 1'b1;
                end
                fnd_pkg::FND_TO_BOOST: begin
                    link.test_out <= 1'b0;
                    link.test_oe <= boost_charge_current;
                end
                default: begin
                    link.test_out <= 1'b0;
                    link.test_oe <= 1'b1;
                end
            endcase
        end
    end
endmodule : fnd_dev

// ---- core/fnd_host.sv ----
`timescale 1ns/100ps
// ==========================================================
// Controller: checks and sends program words over the link
module fnd_host (
    input wire logic ref_clk,
    input wire logic nrst,
    fnd_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    typedef enum logic [1:0] {
        FND_IDLE = 2'b00,
        FND_SHIFT = 2'b01,
        FND_LATCH = 2'b10
    } fnd_state_e;
    // ==========================================================
    // Declarations
    fnd_state_e state_q; // Link sequencer state
    logic [23:0] word_q; // Word being shifted out
    logic [23:0] fb_last_q; // Last feedback word sent
    logic resend_q; // Feedback word must follow
    logic [4:0] bits_q; // Bits left to send
    logic [1:0] div_q; // Half period counter
    logic [11:0] den_q; // Denominator last sent
    logic presc_q; // Prescaler last sent
    logic above2g_q; // Software says input is above 2 GHz
    logic [2:0] stat_q; // Sticky events
    logic [2:0] mask_q; // Event mask
    logic pin_q; // Previous test pin level
    logic take; // Word written while idle
    logic bad; // Word breaks a programming limit
    logic [9:0] nval; // Whole part of a feedback word
    logic [2:0] ev; // Events this cycle
    logic half_done; // Half period elapsed

    // ==========================================================
    // Word checks
    assign nval = {1'b0, wdata[fnd_pkg::WHOLE_LSB +: fnd_pkg::WHOLE_W]};
    always_comb begin
        bad = 1'b0;
        if (wdata[1:0] == fnd_pkg::SEL_FEEDBACK) begin
            if (wdata[fnd_pkg::PART_LSB +: fnd_pkg::PART_W] > den_q) begin
                bad = 1'b1;
            end
            if (nval < (presc_q ? fnd_pkg::NMIN_PRESC8 : fnd_pkg::NMIN_PRESC4)) begin
                bad = 1'b1;
            end
        end else if (wdata[1:0] == fnd_pkg::SEL_REFERENCE) begin
            if (above2g_q && !wdata[fnd_pkg::PRESC_BIT]) begin
                bad = 1'b1;
            end
        end
    end
    assign take = wr && addr == fnd_pkg::OFS_WORD && state_q == FND_IDLE && !resend_q;
    assign half_done = div_q == 2'(fnd_pkg::SCLK_HALF_CYC - 1);

    // ==========================================================
    // Tracking of denominator, prescaler and last feedback word
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            den_q <= 12'h000;
            presc_q <= 1'b0;
            fb_last_q <= 24'h000000;
        end else if (take && !bad) begin
            if (wdata[1:0] == fnd_pkg::SEL_FEEDBACK) begin
                fb_last_q <= wdata[23:0];
            end else if (wdata[1:0] == fnd_pkg::SEL_REFERENCE) begin
                presc_q <= wdata[fnd_pkg::PRESC_BIT];
                if (!wdata[fnd_pkg::LOAD_CTL_BIT]) begin
                    den_q <= wdata[fnd_pkg::DEN_LSB +: fnd_pkg::PART_W];
                end
            end
        end
    end

    // ==========================================================
    // Link sequencer: 24 bits MSB first, then a latch pulse
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= FND_IDLE;
            word_q <= 24'h000000;
            bits_q <= 5'h00;
            div_q <= 2'h0;
            resend_q <= 1'b0;
            link.sclk <= 1'b0;
            link.sdata <= 1'b0;
            link.latch_en <= 1'b0;
        end else begin
            case (state_q)
                FND_IDLE: begin
                    div_q <= 2'h0;
                    if (resend_q) begin
                        word_q <= fb_last_q;
                        link.sdata <= fb_last_q[23];
                        bits_q <= 5'h18;
                        resend_q <= 1'b0;
                        state_q <= FND_SHIFT;
                    end else if (take && !bad) begin
                        word_q <= wdata[23:0];
                        link.sdata <= wdata[23];
                        bits_q <= 5'h18;
                        // A new denominator needs a later feedback word
                        resend_q <= wdata[1:0] == fnd_pkg::SEL_REFERENCE
                            && !wdata[fnd_pkg::LOAD_CTL_BIT];
                        state_q <= FND_SHIFT;
                    end
                end
                FND_SHIFT: begin
                    div_q <= half_done ? 2'h0 : div_q + 2'h1;
                    if (half_done) begin
                        link.sclk <= !link.sclk;
                        if (link.sclk) begin
                            word_q <= {word_q[22:0], 1'b0};
                            link.sdata <= word_q[22];
                            bits_q <= bits_q - 5'h01;
                            if (bits_q == 5'h01) begin
                                state_q <= FND_LATCH;
                            end
                        end
                    end
                end
                FND_LATCH: begin
                    div_q <= half_done ? 2'h0 : div_q + 2'h1;
                    if (half_done) begin
                        link.latch_en <= !link.latch_en;
                        if (link.latch_en) begin
                            state_q <= FND_IDLE;
                        end
                    end
                end
                default: state_q <= FND_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Interrupt status, mask and configuration
    assign ev[fnd_pkg::EV_SENT] = state_q == FND_LATCH && half_done && link.latch_en;
    assign ev[fnd_pkg::EV_REFUSED] = wr && addr == fnd_pkg::OFS_WORD && !(take && !bad);
    assign ev[fnd_pkg::EV_PIN_RISE] = link.test_pin && !pin_q;

    // Set wins over write-one-to-clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= fnd_pkg::IRQ_RST;
            mask_q <= fnd_pkg::IRQ_RST;
            above2g_q <= 1'b0;
            pin_q <= 1'b1;
        end else begin
            pin_q <= link.test_pin;
            if (wr && addr == fnd_pkg::OFS_IRQ_STAT) begin
                stat_q <= (stat_q & ~wdata[2:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            if (wr && addr == fnd_pkg::OFS_IRQ_MASK) begin
                mask_q <= wdata[2:0];
            end
            if (wr && addr == fnd_pkg::OFS_CFG) begin
                above2g_q <= wdata[0];
            end
        end
    end

    // Registered interrupt and read data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            irq <= |(stat_q & mask_q);
            rdata <= 32'h00000000;
            if (rd) begin
                case (addr)
                    fnd_pkg::OFS_WORD: rdata <= {8'h00, fb_last_q};
                    fnd_pkg::OFS_STATUS: rdata <= {29'h0, link.test_pin, resend_q,
                        state_q != FND_IDLE};
                    fnd_pkg::OFS_IRQ_STAT: rdata <= {29'h0, stat_q};
                    fnd_pkg::OFS_IRQ_MASK: rdata <= {29'h0, mask_q};
                    fnd_pkg::OFS_CFG: rdata <= {31'h0, above2g_q};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : fnd_host

// ---- tb/fnd_chk.sv ----
`timescale 1ns/100ps
// ==========================================================
// Watches the serial link, the lock flag and the pump current
module fnd_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_en,
    input wire logic test_out,
    input wire logic test_oe,
    input wire logic [3:0] cp_setting,
    input wire logic [3:0] cp_current,
    input wire logic pd_cycle,
    input wire logic pd_err_lt15,
    input wire logic pd_err_gt30,
    input wire logic digital_lock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sclk_high_hold_a: assert property ($rose(sclk) |=> sclk)
        else $error("serial clock high too short");
    sdata_steady_a: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("data moved at clock rise");
    latch_quiet_a: assert property ($rose(latch_en) |-> !sclk)
        else $error("latch while clock high");
    latch_width_a: assert property ($rose(latch_en) |=> latch_en ##1 !latch_en)
        else $error("latch strobe width wrong");
    lock_drop_a: assert property (pd_cycle && pd_err_gt30 |=> !digital_lock)
        else $error("lock kept after large error");
    // Quiet link for four cycles so a channel write cannot be the cause
    lock_keep_a: assert property (digital_lock && !latch_en && !$past(latch_en)
        && !$past(latch_en, 2) && !$past(latch_en, 3) && !(pd_cycle && pd_err_gt30)
        |=> digital_lock)
        else $error("lock dropped without cause");
    lock_cause_a: assert property ($rose(digital_lock) |-> $past(pd_cycle && pd_err_lt15))
        else $error("lock rose without good cycle");
    boost_current_a: assert property ($past(nrst) |->
        cp_current == fnd_pkg::CP_MAX || cp_current == $past(cp_setting))
        else $error("pump current not setting or max");
    cover property ($rose(digital_lock));
    cover property ($rose(latch_en));
    cover property (test_oe && !test_out);
endmodule : fnd_chk

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb;
    logic ref_clk = 0, nrst = 0, wr = 0, rd = 0, irq, lwin = 0;
    logic pd_cycle = 0, pd_err_lt15 = 0, pd_err_gt30 = 0, rin = 0, hin = 0;
    logic rdo, fbo, lock, presc;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] cp_current;
    logic [8:0] whole;
    logic [11:0] den, rsd;
    logic [2:0] sels [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h6};
    logic exps [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int miscompares = 0, tests_run = 0, cyc = 0, n, k = 0;
    fnd_if link();
    fnd_host fnd_host_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    fnd_dev fnd_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .cp_setting(4'h5),
        .lock_window_length_bit(lwin), .reference_input(rin), .high_freq_input(hin),
        .pd_cycle(pd_cycle), .pd_err_lt15(pd_err_lt15), .pd_err_gt30(pd_err_gt30),
        .cp_current(cp_current), .prescaler_select_bit(presc), .whole_part_value(whole),
        .denominator_value(den), .resync_delay(rsd), .ref_div_out(rdo), .fb_div_out(fbo),
        .digital_lock(lock));
    fnd_chk fnd_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .sclk(link.sclk),
        .sdata(link.sdata), .latch_en(link.latch_en), .test_out(link.test_out),
        .test_oe(link.test_oe), .cp_setting(4'h5), .cp_current(cp_current),
        .pd_cycle(pd_cycle), .pd_err_lt15(pd_err_lt15), .pd_err_gt30(pd_err_gt30),
        .digital_lock(lock));
    always #5 ref_clk = ~ref_clk;
    // Free running inputs and the hang guard
    always @(posedge ref_clk) begin
        rin <= ~rin;
        hin <= ~hin;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end
    function automatic logic [23:0] fb(logic b, logic [8:0] w, logic [11:0] p);
        return {b, w, p, 2'h0};
    endfunction : fb
    function automatic logic [23:0] rf(logic l, logic [2:0] s, logic [3:0] r, logic [11:0] m);
        return {l, s, 1'b0, 1'b0, r, m, 2'h1};
    endfunction : rf
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk) wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk) rd <= 1'b0;
        @(posedge ref_clk) v = rdata;
    endtask : rd_reg
    // Queue a word and wait until sending and any resend are over
    task automatic send(input logic [23:0] w);
        wr_reg(fnd_pkg::OFS_WORD, {8'h00, w});
        repeat (400) begin
            rd_reg(fnd_pkg::OFS_STATUS);
            if (v[1:0] === 2'b00) break;
        end
    endtask : send
    task automatic pulses(input int k, input logic l, input logic g);
        repeat (k) begin
            pd_cycle <= 1'b1;
            pd_err_lt15 <= l;
            pd_err_gt30 <= g;
            @(posedge ref_clk) pd_cycle <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : pulses
    task automatic summarize();
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        send(fb(1'b0, 9'h028, 12'h000));
        `CHK("whole", 9'h028, whole)
        `CHK("cp", 4'h5, cp_current)
        rd_reg(fnd_pkg::OFS_IRQ_STAT);
        `CHK("sent", 1'b1, v[0])
        wr_reg(fnd_pkg::OFS_IRQ_MASK, 32'h1);
        @(posedge ref_clk);
        `CHK("irq on", 1'b1, irq)
        wr_reg(fnd_pkg::OFS_IRQ_STAT, 32'h7);
        @(posedge ref_clk);
        `CHK("irq off", 1'b0, irq)
        send(rf(1'b0, 3'h0, 4'h3, 12'h00A));
        `CHK("den", 12'h00A, den)
        `CHK("presc", 1'b0, presc)
        send(rf(1'b1, 3'h0, 4'h3, 12'h005));
        `CHK("resync", 12'h005, rsd)
        `CHK("den kept", 12'h00A, den)
        send(fb(1'b0, 9'h029, 12'h003));
        `CHK("whole2", 9'h029, whole)
        wr_reg(fnd_pkg::OFS_IRQ_STAT, 32'h7);
        send(fb(1'b0, 9'h014, 12'h000));
        send(fb(1'b0, 9'h02A, 12'h00B));
        rd_reg(fnd_pkg::OFS_IRQ_STAT);
        `CHK("refused", 1'b1, v[1])
        `CHK("whole kept", 9'h029, whole)
        repeat (100) begin
            @(posedge ref_clk);
            if (rdo === 1'b1) break;
        end
        n = 0;
        repeat (60) @(posedge ref_clk) n += int'(rdo === 1'b1);
        `CHK("ref pulses", 10, n)
        n = 0;
        while (k < 11) begin
            n += int'(k > 0);
            @(posedge ref_clk);
            k += int'(fbo === 1'b1);
        end
        `CHK("fb", 826, n)
        pulses(23, 1'b1, 1'b0);
        `CHK("lock 23", 1'b0, lock)
        pulses(1, 1'b1, 1'b0);
        `CHK("lock 24", 1'b1, lock)
        pulses(1, 1'b0, 1'b1);
        `CHK("unlock", 1'b0, lock)
        lwin <= 1'b1;
        pulses(39, 1'b1, 1'b0);
        `CHK("lock 39", 1'b0, lock)
        pulses(1, 1'b1, 1'b0);
        `CHK("lock 40", 1'b1, lock)
        foreach (sels[i]) begin
            send(rf(1'b1, sels[i], 4'h3, 12'h005));
            repeat (3) @(posedge ref_clk);
            `CHK("pin", exps[i], link.test_pin)
        end
        wr_reg(fnd_pkg::OFS_CFG, 32'h1);
        send(rf(1'b1, 3'h7, 4'h3, 12'h005));
        `CHK("2g", 1'b1, link.test_pin)
        send(fb(1'b1, 9'h029, 12'h003));
        repeat (3) @(posedge ref_clk);
        `CHK("boost pin", 1'b0, link.test_pin)
        `CHK("boost cp", fnd_pkg::CP_MAX, cp_current)
        `CHK("new channel", 1'b0, lock)
        summarize();
    end
endmodule : tb
